// ---- hdl/charger_defines.svh ----
// Register offsets, field positions and timing constants of the charger control block
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH
`define A_CUR_CMD 8'h00
`define A_VOLT_CMD 8'h04
`define A_CUR_LIMIT 8'h08
`define A_VOLT_LIMIT 8'h0C
`define A_CUR_DAC 8'h10
`define A_VOLT_DAC 8'h14
`define A_CHG_STATUS 8'h18
`define A_IRQ_STATUS 8'h1C
`define A_IRQ_CLEAR 8'h20
`define A_IRQ_ENABLE 8'h24
`define LIMIT_RST 10'h3FF
`define DAC_ZERO 10'h000
`define PIN_RST 6'h04
`define THERM_LAST 3'h4
`define EV_STATUS 0
`define EV_OVERRANGE 1
`define EV_TIMEOUT 2
`define EV_PAIR 3
`define EV_W 4
`define TIMEOUT_S 180
`define CLK_HZ 40000000
`define WAKE_MA 80
`define WAKE_CODE_RST 10'h008
`endif

// ---- hdl/charger_pkg.sv ----
// Types shared by the charger control block
package charger_pkg;
  typedef enum logic [2:0] {
    therm_normal = 3'h0,
    therm_under_range = 3'h1,
    therm_too_cold = 3'h2,
    therm_too_hot = 3'h3,
    therm_over_range = 3'h4
  } therm_e;
  typedef enum logic [1:0] {
    charging_none = 2'h0,
    charging_wake = 2'h1,
    charging_run = 2'h3
  } chg_state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [2:0] therm;
    logic adapter;
    logic charge_en;
    logic cur_or;
    logic volt_or;
    logic [1:0] state;
  } chg_status_s;
endpackage

// ---- hdl/smart_charger_ctl.sv ----
// Charger controller: enable decision, wake current, command watchdog, DACs, alert line
//
// Functional notes
// - Thermistor over-range (no battery) forces charge enable low.
// - Adapter absent or thermistor hot also forces charge enable low.
// - Battery insertion or adapter connection selects the fixed wake-up current.
// - Wake current stops after timeout when under-range or cold and no commands.
// - Current and voltage pair within timeout loads both DACs and enables charging.
// - Requests above programmed limit are replaced by the limit and flagged.
// - Two 10-bit DAC registers hold charging current and charging voltage.
// - Status-change interrupt asserts whenever any status condition changes.
// - Interrupt clears only on status read or alert response.
// - Interrupt pin is active low open drain.
// - Active-low shutdown input disables the charger while low.
// - Voltage request above nominal limit sets voltage overrange flag.
`timescale 1ns/1ps
`include "charger_defines.svh"
module smart_charger_ctl #(
  parameter int DAC_W = 10,
  parameter logic [32:0] TIMEOUT_CYC = 33'(64'(`TIMEOUT_S) * 64'(`CLK_HZ)),
  parameter logic [9:0] WAKE_CODE = `WAKE_CODE_RST
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input charger_pkg::apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside the clock domain
  input wire logic [2:0] therm_class_in,
  input wire logic adapter_present,
  input wire logic shutdown_n_in,
  input wire logic ara_done_in,
  // Charger and alert outputs
  output logic charge_enable_out,
  output logic charger_run,
  output logic [DAC_W-1:0] cur_dac_out,
  output logic [DAC_W-1:0] volt_dac_out,
  output logic status_change_irq_n_o,
  output logic status_change_irq_n_oe,
  output logic irq
);
  import charger_pkg::*;

  // Three-stage synchronisers; a value is taken once stages two and three agree
  logic [5:0] pin_raw, s1, s2, s3, pin;
  assign pin_raw = {ara_done_in, shutdown_n_in, adapter_present, therm_class_in};
  // Per-bit reset image: no battery, adapter absent, shutdown held, no alert response
  localparam logic [5:0] PIN_RST_V = `PIN_RST;
  for (genvar i = 0; i < 6; i++)
  begin : g_sync
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
        pin[i] <= PIN_RST_V[i];
      end
      else
      begin
        s1[i] <= pin_raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i])
          pin[i] <= s3[i];
      end
    end
  end

  // Thermistor class decode; illegal codes count as no battery
  therm_e therm;
  wire adapter = pin[3];
  wire shutdown_n = pin[4];
  wire ara = pin[5];
  logic ara_q, adapter_q, no_batt_q;
  assign therm = (pin[2:0] > `THERM_LAST) ? therm_over_range : therm_e'(pin[2:0]);
  wire no_batt = (therm == therm_over_range);
  wire hot = (therm == therm_too_hot);
  wire inhibit = no_batt || hot || !adapter;
  wire wake_only = (therm == therm_under_range) || (therm == therm_too_cold);
  wire insert = (adapter && !adapter_q && !no_batt) || (no_batt_q && !no_batt && adapter);
  wire ara_pulse = ara && !ara_q;

  // APB decode: setup captures read data, access phase answers in one cycle
  wire setup = apb_req.psel && !apb_req.penable;
  wire access = apb_req.psel && apb_req.penable && pready;
  wire wr = access && apb_req.pwrite;
  wire [7:0] a = apb_req.paddr;
  wire [9:0] wdat = apb_req.pwdata[9:0];
  wire wr_cur = wr && (a == `A_CUR_CMD);
  wire wr_volt = wr && (a == `A_VOLT_CMD);
  wire status_rd = access && !apb_req.pwrite && (a == `A_CHG_STATUS);
  wire mapped = (a[1:0] == 2'b00) && (a <= `A_IRQ_ENABLE);

  // Registers
  logic [9:0] cur_limit, volt_limit, cur_req, volt_req;
  logic cur_got, volt_got, cur_or, volt_or;
  logic [`EV_W-1:0] irq_status, irq_enable;
  logic [32:0] timer;
  chg_state_e state, next_state;
  logic status_pend;
  chg_status_s stat, stat_q;

  // Clamp against limits
  wire cur_over = wdat > cur_limit;
  wire volt_over = wdat > volt_limit;
  wire [9:0] cur_clamped = cur_over ? cur_limit : wdat;
  wire [9:0] volt_clamped = volt_over ? volt_limit : wdat;
  wire pair_done = (cur_got || wr_cur) && (volt_got || wr_volt);
  wire timeout = (state != charging_none) && (timer >= TIMEOUT_CYC - 33'h1);

  // Limit and enable registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_limit <= `LIMIT_RST;
      volt_limit <= `LIMIT_RST;
      irq_enable <= '0;
    end
    else if (wr)
    begin
      if (a == `A_CUR_LIMIT) cur_limit <= wdat;
      if (a == `A_VOLT_LIMIT) volt_limit <= wdat;
      if (a == `A_IRQ_ENABLE) irq_enable <= apb_req.pwdata[`EV_W-1:0];
    end
  end

  // Command capture with clamping and overrange flags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_req <= `DAC_ZERO;
      volt_req <= `DAC_ZERO;
      cur_or <= 1'b0;
      volt_or <= 1'b0;
      cur_got <= 1'b0;
      volt_got <= 1'b0;
    end
    else
    begin
      if (wr_cur)
      begin
        cur_req <= cur_clamped;
        cur_or <= cur_over;
      end
      if (wr_volt)
      begin
        volt_req <= volt_clamped;
        volt_or <= volt_over;
      end
      cur_got <= !pair_done && !timeout && (cur_got || wr_cur);
      volt_got <= !pair_done && !timeout && (volt_got || wr_volt);
    end
  end

  // Charge state
  always_comb
  begin
    next_state = state;
    unique case (state)
      charging_none:
        if (pair_done) next_state = charging_run;
        else if (insert) next_state = charging_wake;
      charging_wake:
        if (pair_done) next_state = charging_run;
        else if (timeout && wake_only) next_state = charging_none;
        else if (insert) next_state = charging_wake;
      charging_run:
        if (pair_done) next_state = charging_run;
        else if (insert) next_state = charging_wake;
        else if (timeout) next_state = charging_none;
      default: next_state = charging_none;
    endcase
  end

  // Current and voltage value being accepted this cycle
  function automatic logic [9:0] cur_req_n();
    return wr_cur ? cur_clamped : cur_req;
  endfunction
  function automatic logic [9:0] volt_req_n();
    return wr_volt ? volt_clamped : volt_req;
  endfunction

  // State, watchdog and DAC outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= charging_none;
      timer <= '0;
      cur_dac_out <= '0;
      volt_dac_out <= '0;
      charge_enable_out <= 1'b0;
      charger_run <= 1'b0;
    end
    else
    begin
      state <= next_state;
      timer <= (pair_done || insert || timeout || state == charging_none) ? '0 : timer + 33'h1;
      cur_dac_out <= (next_state == charging_run) ? (pair_done ? cur_req_n() : cur_req)
                   : (next_state == charging_wake) ? WAKE_CODE : `DAC_ZERO;
      volt_dac_out <= (next_state == charging_run) ? (pair_done ? volt_req_n() : volt_req)
                    : `DAC_ZERO;
      charge_enable_out <= !inhibit && (next_state != charging_none);
      charger_run <= !inhibit && (next_state != charging_none) && shutdown_n;
    end
  end

  // Status change detection and alert line
  assign stat = '{therm: therm, adapter: adapter, charge_en: charge_enable_out,
                  cur_or: cur_or, volt_or: volt_or, state: state};
  wire stat_change = (stat != stat_q);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_q <= '0;
      status_pend <= 1'b0;
      ara_q <= 1'b0;
      adapter_q <= 1'b0;
      no_batt_q <= 1'b1;
    end
    else
    begin
      stat_q <= stat;
      status_pend <= stat_change || (status_pend && !status_rd && !ara_pulse);
      ara_q <= ara;
      adapter_q <= adapter;
      no_batt_q <= no_batt;
    end
  end
  assign status_change_irq_n_o = 1'b0;
  assign status_change_irq_n_oe = status_pend;

  // Sticky event bits, set wins over clear
  wire [`EV_W-1:0] events = {pair_done, timeout, (wr_cur && cur_over) || (wr_volt && volt_over),
                             stat_change};
  wire [`EV_W-1:0] ev_clr = (wr && a == `A_IRQ_CLEAR) ? apb_req.pwdata[`EV_W-1:0] : '0;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_status <= '0;
    else
      irq_status <= events | (irq_status & ~ev_clr);
  end
  assign irq = |(irq_status & irq_enable);

  // Read mux, captured in the setup cycle
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    unique case (a)
      `A_CUR_LIMIT: rd_mux[9:0] = cur_limit;
      `A_VOLT_LIMIT: rd_mux[9:0] = volt_limit;
      `A_CUR_DAC: rd_mux[DAC_W-1:0] = cur_dac_out;
      `A_VOLT_DAC: rd_mux[DAC_W-1:0] = volt_dac_out;
      `A_CHG_STATUS: rd_mux[$bits(chg_status_s)-1:0] = stat;
      `A_IRQ_STATUS: rd_mux[`EV_W-1:0] = irq_status;
      `A_IRQ_ENABLE: rd_mux[`EV_W-1:0] = irq_enable;
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= setup ? rd_mux : prdata;
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  // Checks
  a_no_batt_off: assert property (@(posedge clk) disable iff (!rstn)
    no_batt |=> !charge_enable_out) else $error("charge enabled without battery");
  a_inhibit_off: assert property (@(posedge clk) disable iff (!rstn)
    (!adapter || hot) |=> !charge_enable_out) else $error("charge enabled while inhibited");
  a_wake_select: assert property (@(posedge clk) disable iff (!rstn)
    (insert && !pair_done) |=> state == charging_wake && cur_dac_out == WAKE_CODE)
    else $error("wake current not selected");
  a_wake_end: assert property (@(posedge clk) disable iff (!rstn)
    (state == charging_wake && timeout && wake_only && !pair_done) |=> state == charging_none
    ##1 cur_dac_out == `DAC_ZERO) else $error("wake current not ended");
  a_pair_load: assert property (@(posedge clk) disable iff (!rstn)
    pair_done |=> state == charging_run && cur_dac_out == cur_req && volt_dac_out == volt_req)
    else $error("command pair not loaded");
  a_clamp_cur: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cur && cur_over) |=> cur_or && cur_req == $past(cur_limit))
    else $error("current not clamped");
  a_clamp_volt: assert property (@(posedge clk) disable iff (!rstn)
    (wr_volt && volt_over) |=> volt_or && volt_req == $past(volt_limit))
    else $error("voltage not clamped");
  a_irq_assert: assert property (@(posedge clk) disable iff (!rstn)
    stat_change |=> !status_change_irq_n_o && status_change_irq_n_oe)
    else $error("alert not asserted");
  a_irq_hold: assert property (@(posedge clk) disable iff (!rstn)
    (status_pend && !status_rd && !ara_pulse) |=> status_pend)
    else $error("alert dropped early");
  a_timer_restart: assert property (@(posedge clk) disable iff (!rstn)
    pair_done |=> timer == '0) else $error("timeout not restarted");
  a_shutdown_off: assert property (@(posedge clk) disable iff (!rstn)
    !shutdown_n |=> !charger_run) else $error("runs during shutdown");
endmodule

// ---- test/battery_host_model.sv ----
// Far side model: battery pins, adapter, alert pull-up and alert response
`timescale 1ns/1ps
module battery_host_model (
  // Clock
  input wire logic clk,
  // Alert pin pair from the charger
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  // Battery, adapter and alert response pins
  output logic [2:0] therm,
  output logic adapter,
  output logic ara,
  // Resolved alert line
  output wire logic alert_n
);
  // Weak pull-up: low only while the charger pulls
  assign alert_n = irq_n_oe ? irq_n_o : 1'b1;
  // No battery, adapter present at time zero
  initial
  begin
    therm = 3'h4;
    adapter = 1'b1;
    ara = 1'b0;
  end
  // Move battery pins just after an edge
  task automatic set_pins(input logic [2:0] t, input logic a);
    @(posedge clk);
    therm <= t;
    adapter <= a;
  endtask
  // Alert response pulse, long enough for the synchroniser
  task automatic ara_pulse();
    @(posedge clk);
    ara <= 1'b1;
    repeat (4) @(posedge clk);
    ara <= 1'b0;
  endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the charger control block
`timescale 1ns/1ps
`include "charger_defines.svh"
module tb_top;
  import charger_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  apb_req_s req = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic [2:0] therm;
  logic adapter, ara, chg_en, run, oe, od, irq;
  wire logic alert_n;
  logic [9:0] cur_dac, volt_dac;
  int n_errors = 0;
  int compares = 0;
  // Rows: class, adapter, expected enable
  logic [4:0] rows [6] = '{5'b000_1_1, 5'b001_1_1, 5'b010_1_1,
                           5'b011_1_0, 5'b100_1_0, 5'b000_0_0};
  // Design with a short watchdog; enable loops back to shutdown
  smart_charger_ctl #(.TIMEOUT_CYC(33'd200)) u_dut (
    .clk(clk), .rstn(rstn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .therm_class_in(therm),
    .adapter_present(adapter), .shutdown_n_in(chg_en), .ara_done_in(ara),
    .charge_enable_out(chg_en), .charger_run(run), .cur_dac_out(cur_dac),
    .volt_dac_out(volt_dac), .status_change_irq_n_o(od),
    .status_change_irq_n_oe(oe), .irq(irq));
  battery_host_model u_far (.clk(clk), .irq_n_o(od), .irq_n_oe(oe),
    .therm(therm), .adapter(adapter), .ara(ara), .alert_n(alert_n));
  // Clock
  always #12.5 clk = ~clk;
  // Watchdog
  initial
  begin
    #500000;
    n_errors++;
    wrap_up();
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Answer is due in the first access cycle
    chk(32'(n), 32'h1);
    req <= '0;
  endtask
  // Read and compare under a mask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Current then voltage command
  task automatic pair(input logic [9:0] c, input logic [9:0] v);
    apb(1'b1, `A_CUR_CMD, {22'h0, c});
    apb(1'b1, `A_VOLT_CMD, {22'h0, v});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Verdict
  task automatic wrap_up();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdchk(`A_CUR_LIMIT, 32'hFFFFFFFF, 32'h3FF);
    rdchk(`A_IRQ_ENABLE, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h28, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({22'h0, cur_dac}, 32'h0);
    foreach (rows[i])
    begin
      u_far.set_pins(rows[i][4:2], rows[i][1]);
      wait_cyc(8);
      pair(10'h55, 10'h66);
      wait_cyc(8);
      chk({31'h0, chg_en}, {31'h0, rows[i][0]});
      chk({31'h0, run}, {31'h0, rows[i][0]});
      if (rows[i][0])
        chk({12'h0, volt_dac, cur_dac}, 32'h19855);
    end
    // Clamping, equal to limit is not overrange
    u_far.set_pins(3'h0, 1'b1);
    apb(1'b1, `A_CUR_LIMIT, 32'h100);
    apb(1'b1, `A_VOLT_LIMIT, 32'h200);
    pair(10'h3FF, 10'h200);
    wait_cyc(2);
    chk({12'h0, volt_dac, cur_dac}, 32'h80100);
    rdchk(`A_CHG_STATUS, 32'hC, 32'h8);
    rdchk(`A_CUR_DAC, 32'hFFFFFFFF, 32'h100);
    pair(10'h100, 10'h201);
    wait_cyc(2);
    rdchk(`A_CHG_STATUS, 32'hC, 32'h4);
    rdchk(`A_VOLT_DAC, 32'hFFFFFFFF, 32'h200);
    // Watchdog restart and expiry
    wait_cyc(150);
    pair(10'h40, 10'h80);
    wait_cyc(150);
    chk({22'h0, cur_dac}, 32'h40);
    wait_cyc(80);
    chk({22'h0, cur_dac}, 32'h0);
    chk({31'h0, chg_en}, 32'h0);
    rdchk(`A_IRQ_STATUS, 32'hE, 32'hE);
    // Insertion of a cold battery: wake current, then expiry
    u_far.set_pins(3'h4, 1'b1);
    wait_cyc(8);
    u_far.set_pins(3'h2, 1'b1);
    wait_cyc(8);
    chk({12'h0, volt_dac, cur_dac}, {22'h0, `WAKE_CODE_RST});
    wait_cyc(210);
    chk({22'h0, cur_dac}, 32'h0);
    // Alert line, status read, alert response, interrupt register set
    rdchk(`A_CHG_STATUS, 32'h1C0, 32'h80);
    wait_cyc(2);
    chk({31'h0, oe}, 32'h0);
    apb(1'b1, `A_IRQ_CLEAR, 32'hF);
    apb(1'b1, `A_IRQ_ENABLE, 32'h1);
    rdchk(`A_IRQ_ENABLE, 32'hF, 32'h1);
    chk({31'h0, irq}, 32'h0);
    u_far.set_pins(3'h3, 1'b1);
    wait_cyc(8);
    chk({31'h0, alert_n}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    u_far.ara_pulse();
    wait_cyc(8);
    chk({31'h0, alert_n}, 32'h1);
    apb(1'b1, `A_IRQ_CLEAR, 32'h1);
    wait_cyc(2);
    chk({31'h0, irq}, 32'h0);
    rdchk(`A_IRQ_STATUS, 32'h1, 32'h0);
    // Mid-run reset returns limits and enables to their reset values
    apb(1'b1, `A_CUR_LIMIT, 32'h80);
    rdchk(`A_CUR_LIMIT, 32'hFFFFFFFF, 32'h80);
    rstn <= 1'b0;
    wait_cyc(3);
    rstn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    rdchk(`A_CUR_LIMIT, 32'hFFFFFFFF, 32'h3FF);
    rdchk(`A_IRQ_ENABLE, 32'hF, 32'h0);
    chk({31'h0, oe}, 32'h1);
    wrap_up();
  end
endmodule
